// >>> hdl/ect_handler.sv
// Notes on behaviour
// - telegram 81 sends six words: status two, sensor status, incr, abs.
// - telegram 82 is telegram 81 plus short velocity in word seven.
// - telegram 83 is telegram 81 plus long velocity in words seven-eight.
// - telegram 84: status two, sensor status, wide abs, abs, long vel.
// - velocities signed two's complement, 16/32 bits, MSB first.
// - clockwise sequence gives positive velocity, counter-clockwise negative.
// - velocity unit follows normalization setting; rpm after reset.
// - class four only: bit 11 picks absolute load or relative offset.
// - class four only: preset fires on rising bit 12 outside park, not on level.
// - preset leaves incremental position untouched.
// - bit 13 set sends absolute position cyclically, else none; telegram 84 wide abs words carry it regardless of bit 13.
// - bit 14 park stops monitoring, telegram positions, errors; sign-of-life runs.
// - bit 15 clears error code only when error is clearable.
// - status bit 15 shows error present, acknowledgement needed.
// - only classes three and four; preset bits act in four only.
// - during error, abs position word carries sixteen-bit error code.
// - error holds until cause gone and bit 15 rises.
// - wide absolute position upper thirty-two bits are zero.
// - status bits 12-14 echo requests, bit 12 in class four only; bit 11 shows acknowledge busy.
`timescale 1ns/1ps
`default_nettype none
`include "ect_regs.svh"

module ect_handler (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic cyc_strobe,
    input wire logic [15:0] encoder_control_word_two,
    input wire logic [15:0] sensor_control_word,
    input wire logic [15:0] encoder_status_word_two,
    input wire logic [31:0] raw_position,
    input wire logic [31:0] vel_rpm,
    input wire logic [31:0] vel_alt,
    input wire logic err_cause,
    input wire logic [15:0] err_code,
    input wire logic err_clearable,
    output logic tx_valid,
    output logic [15:0] tx_word,
    output logic tx_last
);
    ect_pkg::ect_core_s s_r;
    ect_pkg::ect_core_s s_nxt;
    ect_mem_if mif ();

    logic [1:0] tel;
    logic tel84;
    logic cl4;
    logic park;
    logic fire;
    logic ack_edge;
    logic [3:0] len;
    logic [31:0] off;
    logic signed [31:0] vel_sel;
    logic signed [31:0] vel_sgn;
    logic [15:0] stat_w;
    logic [31:0] inc_w;
    logic [31:0] wide_w;
    logic [31:0] absw;
    logic [15:0] fword;
    logic mem_we;
    logic mem_re;

    // ----------------------------------------------------------------
    // decoded control and derived values
    // ----------------------------------------------------------------
    assign tel = s_r.cfg[`ECT_CFG_TEL_HI:0];
    assign tel84 = (tel == `ECT_TEL_84);
    assign cl4 = s_r.cfg[`ECT_CFG_CL4];
    assign park = s_r.ctl_cur[`ECT_SCW_PARK];
    // preset bits only count in class four and outside park
    assign fire = cl4 && !park && s_r.ctl_cur[`ECT_SCW_PTRIG] &&
                  !s_r.ctl_prev[`ECT_SCW_PTRIG];
    assign ack_edge = s_r.ctl_cur[`ECT_SCW_ACK] &&
                      !s_r.ctl_prev[`ECT_SCW_ACK];

    always_comb begin
        case (tel)
            `ECT_TEL_81: len = `ECT_LEN_81;
            `ECT_TEL_82: len = `ECT_LEN_82;
            `ECT_TEL_83: len = `ECT_LEN_83;
            default: len = `ECT_LEN_84;
        endcase
    end

    // unit select: the sensor supplies both scalings, we pick one
    assign vel_sel = s_r.cfg[`ECT_CFG_UNIT] ? vel_alt : vel_rpm;
    assign vel_sgn = s_r.cfg[`ECT_CFG_CCW] ? -vel_sel : vel_sel;

    always_comb begin
        stat_w = 16'h0000;
        stat_w[`ECT_SSW_ACKBUSY] = s_r.ctl_cur[`ECT_SCW_ACK];
        stat_w[`ECT_SSW_PRESET] = cl4 &&
                                  s_r.ctl_cur[`ECT_SCW_PTRIG];
        stat_w[`ECT_SSW_ABSREQ] = s_r.ctl_cur[`ECT_SCW_ABSREQ];
        stat_w[`ECT_SSW_PARK] = park;
        stat_w[`ECT_SSW_ERR] = s_r.err && !park;
    end

    // park silences position words but the status words keep flowing
    assign inc_w = park ? 32'h0000_0000 : s_r.inc;
    assign wide_w = park ? 32'h0000_0000 : s_r.abs;
    always_comb begin
        if (park) begin
            absw = 32'h0000_0000;
        end else if (s_r.err) begin
            absw = {16'h0000, s_r.code};
        end else if (s_r.ctl_cur[`ECT_SCW_ABSREQ]) begin
            absw = s_r.abs;
        end else begin
            absw = 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // input word layout, high word of each value first
    // ----------------------------------------------------------------
    always_comb begin
        case (s_r.idx)
            4'h0: fword = s_r.sw2;
            4'h1: fword = stat_w;
            4'h2: fword = tel84 ? 16'h0000 : inc_w[31:16];
            4'h3: fword = tel84 ? 16'h0000 : inc_w[15:0];
            4'h4: fword = tel84 ? wide_w[31:16] : absw[31:16];
            4'h5: fword = tel84 ? wide_w[15:0] : absw[15:0];
            4'h6: begin
                if (tel84) begin
                    fword = absw[31:16];
                end else if (tel == `ECT_TEL_82) begin
                    fword = s_r.vel_s;
                end else begin
                    fword = s_r.vel_l[31:16];
                end
            end
            4'h7: fword = tel84 ? absw[15:0] : s_r.vel_l[15:0];
            4'h8: fword = s_r.vel_l[31:16];
            4'h9: fword = s_r.vel_l[15:0];
            default: fword = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        off = s_r.offset;
        mem_we = 1'b0;
        mem_re = 1'b0;
        s_nxt.tx_valid = 1'b0;
        s_nxt.tx_last = 1'b0;
        s_nxt.rdata = 32'h0000_0000;
        if (bus_wr) begin
            case (bus_addr)
                `ECT_ADDR_CONFIG: s_nxt.cfg = bus_wdata[`ECT_CFG_W-1:0];
                `ECT_ADDR_PRESET: s_nxt.preset = bus_wdata;
                default: ;
            endcase
        end
        if (bus_rd) begin
            case (bus_addr)
                `ECT_ADDR_CONFIG: s_nxt.rdata = {27'h000_0000, s_r.cfg};
                `ECT_ADDR_PRESET: s_nxt.rdata = s_r.preset;
                `ECT_ADDR_STATUS: s_nxt.rdata = {s_r.ctl_two, stat_w};
                `ECT_ADDR_ABSPOS: s_nxt.rdata = s_r.abs;
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        case (s_r.st)
            ect_pkg::ect_st_idle: begin
                if (cyc_strobe) begin
                    s_nxt.ctl_prev = s_r.ctl_cur;
                    s_nxt.ctl_cur = sensor_control_word;
                    s_nxt.ctl_two = encoder_control_word_two;
                    s_nxt.st = ect_pkg::ect_st_apply;
                end
            end
            ect_pkg::ect_st_apply: begin
                if (fire) begin
                    if (s_r.ctl_cur[`ECT_SCW_PMODE]) begin
                        off = s_r.offset + s_r.preset;
                    end else begin
                        off = s_r.preset - raw_position;
                    end
                end
                s_nxt.offset = off;
                // one snapshot per exchange keeps position, velocity and status two words coherent
                s_nxt.inc = raw_position;
                s_nxt.abs = raw_position + off;
                s_nxt.sw2 = encoder_status_word_two;
                s_nxt.vel_l = vel_sgn;
                if (vel_sgn > `ECT_VS_MAX) begin
                    s_nxt.vel_s = 16'h7fff;
                end else if (vel_sgn < `ECT_VS_MIN) begin
                    s_nxt.vel_s = 16'h8000;
                end else begin
                    s_nxt.vel_s = vel_sgn[15:0];
                end
                if (ack_edge && !err_cause && s_r.err_clr) begin
                    s_nxt.err = 1'b0;
                end
                s_nxt.idx = 4'h0;
                s_nxt.st = ect_pkg::ect_st_fill;
            end
            ect_pkg::ect_st_fill: begin
                mem_we = 1'b1;
                if (s_r.idx == len - 4'h1) begin
                    s_nxt.idx = 4'h0;
                    s_nxt.st = ect_pkg::ect_st_send;
                end else begin
                    s_nxt.idx = s_r.idx + 4'h1;
                end
            end
            ect_pkg::ect_st_send: begin
                mem_re = 1'b1;
                s_nxt.tx_valid = 1'b1;
                if (s_r.idx == len - 4'h1) begin
                    s_nxt.tx_last = 1'b1;
                    s_nxt.idx = 4'h0;
                    s_nxt.st = ect_pkg::ect_st_idle;
                end else begin
                    s_nxt.idx = s_r.idx + 4'h1;
                end
            end
            default: s_nxt.st = ect_pkg::ect_st_idle;
        endcase
        // a live cause wins over a clear in the same cycle
        if (err_cause && !park) begin
            if (!s_r.err) begin
                s_nxt.code = err_code;
                s_nxt.err_clr = err_clearable;
            end
            s_nxt.err = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: ect_pkg::ect_st_idle, cfg: `ECT_CFG_RST,
                     preset: `ECT_PRESET_RST, default: '0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // frame store
    // ----------------------------------------------------------------
    assign mif.we = mem_we;
    assign mif.waddr = s_r.idx;
    assign mif.wdata = fword;
    assign mif.re = mem_re;
    assign mif.raddr = s_r.idx;

    ect_frame_mem u_mem (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .m(mif.mem)
    );

    assign bus_rdata = s_r.rdata;
    assign tx_valid = s_r.tx_valid;
    assign tx_last = s_r.tx_last;
    assign tx_word = mif.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_CAPTURE: assert property (
        (ce && cyc_strobe && s_r.st == ect_pkg::ect_st_idle) |=>
        (s_r.ctl_prev == $past(s_r.ctl_cur) &&
         s_r.ctl_cur == $past(sensor_control_word)))
        else $error("control words not captured per exchange");
    AST_PRESET_ABS: assert property (
        (ce && s_r.st == ect_pkg::ect_st_apply && fire &&
         !s_r.ctl_cur[`ECT_SCW_PMODE]) |=> (s_r.abs == $past(s_r.preset)))
        else $error("absolute preset not loaded");
    AST_PRESET_REL: assert property (
        (ce && s_r.st == ect_pkg::ect_st_apply && fire &&
         s_r.ctl_cur[`ECT_SCW_PMODE]) |=>
        (s_r.offset == 32'($past(s_r.offset) + $past(s_r.preset))))
        else $error("relative preset offset wrong");
    AST_NO_RETRIGGER: assert property (
        (ce && s_r.st == ect_pkg::ect_st_apply &&
         s_r.ctl_prev[`ECT_SCW_PTRIG]) |=> $stable(s_r.offset))
        else $error("preset fired on a steady level");
    AST_CL3_PRESET: assert property (
        (ce && s_r.st == ect_pkg::ect_st_apply && !cl4) |=>
        $stable(s_r.offset))
        else $error("preset acted outside class four");
    AST_INC_WORD: assert property (
        (mem_we && !tel84 && !park && s_r.idx == 4'h3) |->
        (fword == s_r.inc[15:0]))
        else $error("incremental word differs from raw position");
    AST_ERR_HOLD: assert property (
        (ce && err_cause && !park) |=> s_r.err)
        else $error("error dropped while cause present");
    AST_ERR_CODE: assert property (
        (mem_we && s_r.err && !park &&
         s_r.idx == (tel84 ? 4'h7 : 4'h5)) |-> (fword == s_r.code))
        else $error("error code missing from position word");
    AST_ERR_FLAG: assert property (
        (mem_we && s_r.idx == 4'h1) |->
        (fword[`ECT_SSW_ERR] == (s_r.err && !park)))
        else $error("status error bit wrong");
    AST_WIDE_ZERO: assert property (
        (mem_we && tel84 && (s_r.idx == 4'h2 || s_r.idx == 4'h3)) |->
        (fword == 16'h0000))
        else $error("wide position upper half not zero");
    AST_VEL_SIGN: assert property (
        (ce && s_r.st == ect_pkg::ect_st_apply) |=>
        (s_r.vel_l == $past(vel_sgn)))
        else $error("velocity sign or value wrong");
    AST_FRAME_LEN: assert property (
        (ce && s_r.st == ect_pkg::ect_st_send && s_r.idx == len - 4'h1) |=>
        (tx_valid && tx_last))
        else $error("frame length wrong");

    COV_PRESET: cover property (ce && fire);
    COV_ERR_CLEAR: cover property (s_r.err ##1 !s_r.err);
    COV_TEL84: cover property (tx_last && tel84);
    COV_PARK: cover property (park && tx_valid);
endmodule

`default_nettype wire

// >>> hdl/ect_regs.svh
`ifndef ECT_REGS_SVH
`define ECT_REGS_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define ECT_ADDR_CONFIG 8'h00
`define ECT_ADDR_PRESET 8'h04
`define ECT_ADDR_STATUS 8'h08
`define ECT_ADDR_ABSPOS 8'h0c

// ----------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------
`define ECT_CFG_W 5
`define ECT_CFG_TEL_HI 1
`define ECT_CFG_CL4 2
`define ECT_CFG_CCW 3
`define ECT_CFG_UNIT 4
`define ECT_CFG_RST 5'h04
`define ECT_PRESET_RST 32'h0000_0000

// telegram select codes in the config word
`define ECT_TEL_81 2'h0
`define ECT_TEL_82 2'h1
`define ECT_TEL_83 2'h2
`define ECT_TEL_84 2'h3

// input words per telegram
`define ECT_LEN_81 4'h6
`define ECT_LEN_82 4'h7
`define ECT_LEN_83 4'h8
`define ECT_LEN_84 4'ha
`define ECT_FRAME_WORDS 10

// ----------------------------------------------------------------
// sensor control word and sensor status word bits
// ----------------------------------------------------------------
`define ECT_SCW_PMODE 11
`define ECT_SCW_PTRIG 12
`define ECT_SCW_ABSREQ 13
`define ECT_SCW_PARK 14
`define ECT_SCW_ACK 15
`define ECT_SSW_ACKBUSY 11
`define ECT_SSW_PRESET 12
`define ECT_SSW_ABSREQ 13
`define ECT_SSW_PARK 14
`define ECT_SSW_ERR 15

// short velocity saturation limits
`define ECT_VS_MAX 32'sh0000_7fff
`define ECT_VS_MIN 32'shffff_8000

`endif

// >>> hdl/ect_pkg.sv
package ect_pkg;

    typedef enum logic [3:0] {
        ect_st_idle  = 4'b0001,
        ect_st_apply = 4'b0010,
        ect_st_fill  = 4'b0100,
        ect_st_send  = 4'b1000
    } ect_state_e;

    typedef struct packed {
        ect_state_e st;
        logic [15:0] ctl_two;
        logic [15:0] ctl_cur;
        logic [15:0] ctl_prev;
        logic [31:0] offset;
        logic err;
        logic err_clr;
        logic [15:0] code;
        logic [3:0] idx;
        logic tx_valid;
        logic tx_last;
        logic [4:0] cfg;
        logic [31:0] preset;
        logic [31:0] rdata;
        logic [15:0] sw2;
        logic [31:0] inc;
        logic [31:0] abs;
        logic [31:0] vel_l;
        logic [15:0] vel_s;
    } ect_core_s;

    typedef struct packed {
        logic [9:0][15:0] words;
        logic [15:0] rdata;
    } ect_mem_s;

endpackage

// >>> hdl/ect_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ect_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [15:0] wdata;
    logic re;
    logic [3:0] raddr;
    logic [15:0] rdata;

    modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
    modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

`default_nettype wire

// >>> hdl/ect_frame_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "ect_regs.svh"

module ect_frame_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    ect_mem_if.mem m
);
    ect_pkg::ect_mem_s s_r;
    ect_pkg::ect_mem_s s_nxt;

    // ----------------------------------------------------------------
    // frame word store, read data registered
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (m.we && (m.waddr < 4'(`ECT_FRAME_WORDS))) begin
            s_nxt.words[m.waddr] = m.wdata;
        end
        if (m.re && (m.raddr < 4'(`ECT_FRAME_WORDS))) begin
            s_nxt.rdata = s_r.words[m.raddr];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign m.rdata = s_r.rdata;
endmodule

`default_nettype wire

// >>> sim/ect_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module ect_master_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [15:0] tx_word,
    input wire logic tx_last,
    output logic cyc_strobe,
    output logic [15:0] ctl_two,
    output logic [15:0] ctl_sensor
);
    logic [15:0] rx_q[$];

    initial begin
        cyc_strobe = 1'b0;
        ctl_two = 16'h0000;
        ctl_sensor = 16'h0000;
    end

    // idle gives a slow master; zero answers at once
    task automatic exchange(input logic [15:0] c2, input logic [15:0] sc,
                            input int idle);
        repeat (idle) @(posedge clk);
        rx_q.delete();
        cyc_strobe <= 1'b1;
        ctl_two <= c2;
        ctl_sensor <= sc;
        @(posedge clk);
        cyc_strobe <= 1'b0;
        // words mean nothing outside the strobe, so show junk there
        ctl_two <= ~c2;
        ctl_sensor <= ~sc;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (tx_valid === 1'b1) begin
                rx_q.push_back(tx_word);
                if (tx_last === 1'b1) break;
            end
        end
    endtask
endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ect_regs.svh"

module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0, bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic cyc_strobe, tx_valid, tx_last;
    logic [15:0] ctl2, scw, tx_word;
    logic [15:0] sw2 = 16'h0000, code = 16'h0000;
    logic [31:0] raw = 32'h0000_0000;
    logic [31:0] vrpm = 32'h0000_0000, valt = 32'h0000_0000;
    logic cause = 1'b0, clr = 1'b0;
    int failures = 0, cmp_count = 0;
    logic [31:0] seed = 32'hb29e_225d;
    // ------------------------------------------------------------
    // reference state
    // ------------------------------------------------------------
    logic [4:0] cfg = `ECT_CFG_RST;
    logic [31:0] preset = 32'h0000_0000, offset = 32'h0000_0000, labs;
    logic err = 1'b0, eclr = 1'b0;
    logic [15:0] ecode, prev = 16'h0000, lc2, lss;
    logic [15:0] exp_q[$];

    initial forever #25 clk = ~clk;

    ect_handler u_dut (.clk(clk), .rst(rst), .ce(1'b1),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cyc_strobe(cyc_strobe),
        .encoder_control_word_two(ctl2), .sensor_control_word(scw),
        .encoder_status_word_two(sw2), .raw_position(raw),
        .vel_rpm(vrpm), .vel_alt(valt), .err_cause(cause),
        .err_code(code), .err_clearable(clr), .tx_valid(tx_valid),
        .tx_word(tx_word), .tx_last(tx_last));

    ect_master_model u_master (.clk(clk), .tx_valid(tx_valid),
        .tx_word(tx_word), .tx_last(tx_last), .cyc_strobe(cyc_strobe),
        .ctl_two(ctl2), .ctl_sensor(scw));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v);
        if ($signed(v) > 32'sh0000_7fff) return 16'h7fff;
        if ($signed(v) < 32'shffff_8000) return 16'h8000;
        return v[15:0];
    endfunction

    task automatic end_sim();
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] ex);
        cmp_count++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, ex);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] ex);
        cmp_count++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %0t reg got %h exp %h", $time, got, ex);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        chk_reg(bus_rdata, ex);
    endtask

    task automatic set_cfg(input logic [4:0] c);
        cfg = c;
        wr(`ECT_ADDR_CONFIG, {27'h000_0000, c});
    endtask

    // ------------------------------------------------------------
    // one cyclic exchange against the reference
    // ------------------------------------------------------------
    task automatic xchg(input logic [15:0] sc, input int idle);
        logic [31:0] r, a, aw, v, vr, va, inc;
        logic [15:0] s2, c2;
        logic park;
        r = rnd();
        vr = $signed(rnd()) >>> 12;
        va = $signed(rnd()) >>> 12;
        s2 = 16'(rnd());
        c2 = 16'(rnd());
        park = sc[14];
        @(posedge clk);
        raw <= r;
        vrpm <= vr;
        valt <= va;
        sw2 <= s2;
        if (cfg[2] && !park && sc[12] && !prev[12])
            offset = sc[11] ? offset + preset : preset - r;
        if (err && sc[15] && !prev[15] && !cause && eclr)
            err = 1'b0;
        if (cause && !park && !err) begin
            err = 1'b1;
            ecode = code;
            eclr = clr;
        end
        prev = sc;
        labs = r + offset;
        a = park ? 32'h0000_0000 : labs;
        inc = park ? 32'h0000_0000 : r;
        aw = park ? 32'h0000_0000 : err ? {16'h0000, ecode} :
             sc[13] ? a : 32'h0000_0000;
        v = cfg[4] ? va : vr;
        if (cfg[3]) v = -v;
        lss = {err & ~park, sc[14:13], cfg[2] & sc[12], sc[15], 11'h000};
        lc2 = c2;
        exp_q = {s2, lss};
        if (cfg[1:0] == `ECT_TEL_84)
            exp_q = {exp_q, 16'h0000, 16'h0000, a[31:16], a[15:0]};
        else
            exp_q = {exp_q, inc[31:16], inc[15:0]};
        exp_q = {exp_q, aw[31:16], aw[15:0]};
        if (cfg[1:0] == `ECT_TEL_82) exp_q.push_back(sat16(v));
        if (cfg[1:0] >= `ECT_TEL_83) exp_q = {exp_q, v[31:16], v[15:0]};
        u_master.exchange(c2, sc, idle);
        chk_word(16'(u_master.rx_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            chk_word(u_master.rx_q[i], exp_q[i]);
    endtask

    initial begin
        #2_000_000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`ECT_ADDR_CONFIG, 32'h0000_0004);
        rd(`ECT_ADDR_PRESET, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        wr(`ECT_ADDR_STATUS, 32'hffff_ffff);
        rd(`ECT_ADDR_STATUS, 32'h0000_0000);
        for (int t = 0; t < 4; t++)
            for (int k = 0; k < 4; k++) begin
                set_cfg({k[1:0], 1'b1, t[1:0]});
                xchg(16'(rnd()) & 16'h27ff, k);
            end
        preset = rnd();
        wr(`ECT_ADDR_PRESET, preset);
        set_cfg(5'h07);
        xchg(16'h3000, 0);
        xchg(16'h3000, 2);
        rd(`ECT_ADDR_ABSPOS, labs);
        xchg(16'h2000, 0);
        xchg(16'h3800, 1);
        set_cfg(5'h03);
        xchg(16'h2000, 0);
        xchg(16'h3800, 0);
        set_cfg(5'h04);
        @(posedge clk);
        cause <= 1'b1;
        code <= 16'(rnd());
        clr <= 1'b1;
        xchg(16'h2000, 0);
        xchg(16'ha000, 0);
        @(posedge clk);
        cause <= 1'b0;
        xchg(16'h2000, 0);
        xchg(16'ha000, 0);
        @(posedge clk);
        cause <= 1'b1;
        clr <= 1'b0;
        xchg(16'h2000, 0);
        @(posedge clk);
        cause <= 1'b0;
        xchg(16'ha000, 0);
        xchg(16'h6000, 1);
        rd(`ECT_ADDR_STATUS, {lc2, lss});
        end_sim();
    end
endmodule

`default_nettype wire
